// ---- design/rdam_top.sv ----
// Reference path divider, modulator clock select and aux output mux.
`default_nettype none
module rdam_top
   import rdam_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic square_reference_pin_i,
   input wire logic sine_reference_pin_i,
   input wire logic vco_prescaler_pin_i,
   input wire rdam_reg_wr_s reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_rd_addr_i,
   input wire logic signed [3:0] dsm_step_i,
   input wire rdam_aux_src_s aux_src_i,
   output logic [23:0] reg_rdata_o,
   output logic pfd_ref_o,
   output logic pfd_vco_o,
   output logic mod_clk_o,
   output logic aux_output_pin_first_o,
   output logic aux_output_pin_second_o,
   output logic aux_output_pin_third_o
);
   // ==========================================================
   // State
   typedef struct packed {
      logic [2:0] sy1;
      logic [2:0] sy2;
      logic [2:0] sy3;
      logic [2:0] lvl;
      logic [2:0] tick;
      logic [15:0] rdiv;
      logic [5:0] rin;
      logic [6:0] aux;
      logic [17:0] nreg;
      logic path;
      logic pfd;
      logic [2:0] gpo;
      logic modclk;
      logic [23:0] rdata;
   } rdam_top_s;

   rdam_top_s s_q;
   rdam_top_s s_d;

   logic auto_mode;
   logic [13:0] ratio;
   logic div_run;
   logic use_div;
   logic ref_lvl;
   logic ref_tick;
   logic div_out;
   logic div_wrap;
   logic n_frac;
   logic [16:0] n_lo;
   logic [16:0] n_hi;
   logic [16:0] n_avg;
   logic signed [3:0] step;
   logic [17:0] n_inst;
   logic [16:0] n_half;
   logic n_out;
   logic [2:0] agree;

   // ==========================================================
   // Reference path decode
   always_comb begin
      auto_mode = s_q.rdiv[RDAM_RD_AUTO];
      ratio = s_q.rdiv[13:0];
      // Auto mode looks only at the ratio.
      if (auto_mode) begin
         div_run = ratio >= RDAM_RATIO_MIN_DIV;
         use_div = ratio >= RDAM_RATIO_MIN_DIV;
      end else begin
         div_run = s_q.rin[RDAM_RIN_DIV_EN];
         use_div = s_q.rdiv[RDAM_RD_PATH];
      end
      // A disabled buffer is masked out of ref_lvl and ref_tick, so only the selected and
      // enabled input can reach the divider.
      if (s_q.rin[RDAM_RIN_SIN_SEL]) begin
         ref_lvl = s_q.rin[RDAM_RIN_SIN_EN] & s_q.lvl[RDAM_PIN_SIN];
         ref_tick = s_q.rin[RDAM_RIN_SIN_EN] & s_q.tick[RDAM_PIN_SIN];
      end else begin
         ref_lvl = s_q.rin[RDAM_RIN_SQ_EN] & s_q.lvl[RDAM_PIN_SQ];
         ref_tick = s_q.rin[RDAM_RIN_SQ_EN] & s_q.tick[RDAM_PIN_SQ];
      end
   end

   // ==========================================================
   // VCO path ratio
   always_comb begin
      n_frac = s_q.nreg[RDAM_N_FRAC];
      n_lo = n_frac ? RDAM_N_MIN_FRAC : RDAM_N_MIN_INT;
      n_hi = n_frac ? RDAM_N_MAX_FRAC : RDAM_N_MAX_INT;
      n_avg = s_q.nreg[16:0];
      if (n_avg < n_lo) begin
         n_avg = n_lo;
      end else if (n_avg > n_hi) begin
         n_avg = n_hi;
      end
      n_avg[0] = 1'b0;
      step = 4'sh0;
      if (n_frac) begin
         step = dsm_step_i;
         if (step > RDAM_STEP_MAX) begin
            step = RDAM_STEP_MAX;
         end else if (step < -RDAM_STEP_MAX) begin
            step = -RDAM_STEP_MAX;
         end
         step[0] = 1'b0;
      end
      n_inst = 18'({1'b0, n_avg}) + 18'({{14{step[3]}}, step});
      // The fixed halving stage sits ahead of the prescaler pin.
      n_half = n_inst[17:1];
   end

   rdam_divider #(
      .W(14)
   ) u_ref_div (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .run_i(div_run),
      .tick_i(ref_tick),
      .ratio_i(ratio),
      .out_o(div_out),
      .wrap_o(div_wrap)
   );

   rdam_divider #(
      .W(17)
   ) u_vco_div (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .run_i(1'b1),
      .tick_i(s_q.tick[RDAM_PIN_VCO]),
      .ratio_i(n_half),
      .out_o(n_out),
      .wrap_o()
   );

   // ==========================================================
   // Next state
   always_comb begin
      s_d = s_q;
      // Pins are asynchronous; a change counts once stages two and
      // three agree, which rejects single-sample glitches.
      s_d.sy1 = {vco_prescaler_pin_i, sine_reference_pin_i,
                 square_reference_pin_i};
      s_d.sy2 = s_q.sy1;
      s_d.sy3 = s_q.sy2;
      agree = ~(s_q.sy2 ^ s_q.sy3);
      s_d.lvl = (agree & s_q.sy3) | (~agree & s_q.lvl);
      s_d.tick = s_d.lvl & ~s_q.lvl;
      if (reg_wr_i.en) begin
         unique case (reg_wr_i.addr)
            RDAM_OFS_REF_INPUT: s_d.rin = reg_wr_i.data[5:0];
            RDAM_OFS_REF_DIV: s_d.rdiv = reg_wr_i.data[15:0];
            RDAM_OFS_AUX_OUT: s_d.aux = reg_wr_i.data[6:0];
            RDAM_OFS_N_RATIO: s_d.nreg = reg_wr_i.data[17:0];
            default: s_d.rin = s_q.rin;
         endcase
      end
      if (div_wrap || !div_run) begin
         s_d.path = use_div;
      end
      s_d.pfd = s_q.path ? div_out : ref_lvl;
      if (s_q.rin[RDAM_RIN_SQ2DIG]) begin
         s_d.modclk = s_q.rin[RDAM_RIN_DSM_SIN] ? s_q.lvl[RDAM_PIN_SIN]
                      : s_q.lvl[RDAM_PIN_SQ];
      end else begin
         s_d.modclk = ref_lvl;
      end
      // Pin order in gpo is {third, second, first}.
      case (s_q.aux[3:0])
         RDAM_GPO_STATIC: s_d.gpo = s_q.aux[6:4];
         RDAM_GPO_CLOCKS: s_d.gpo = {ref_lvl, div_out,
                                     s_q.lvl[RDAM_PIN_VCO]};
         RDAM_GPO_LOCK: s_d.gpo = aux_src_i.lock_win;
         RDAM_GPO_SLIP: s_d.gpo = aux_src_i.slip;
         RDAM_GPO_FRAC: s_d.gpo = {s_q.lvl[RDAM_PIN_SIN], div_out,
                                   aux_src_i.frac_strobe};
         RDAM_GPO_ACC: s_d.gpo = aux_src_i.dsm_acc;
         RDAM_GPO_OSC: s_d.gpo = aux_src_i.aux_osc;
         RDAM_GPO_MVCO: s_d.gpo = aux_src_i.multi_vco;
         RDAM_GPO_DSM: s_d.gpo = aux_src_i.dsm_out;
         default: s_d.gpo = 3'h0;
      endcase
      if (reg_rd_i) begin
         unique case (reg_rd_addr_i)
            RDAM_OFS_REF_INPUT: s_d.rdata = {18'h0_0000, s_q.rin};
            RDAM_OFS_REF_DIV: s_d.rdata = {8'h00, s_q.rdiv};
            RDAM_OFS_AUX_OUT: s_d.rdata = {17'h0_0000, s_q.aux};
            RDAM_OFS_N_RATIO: s_d.rdata = {6'h00, s_q.nreg};
            RDAM_OFS_STATUS: s_d.rdata = {19'h0_0000, s_q.path,
                                          div_run, s_q.lvl};
            default: s_d.rdata = 24'h00_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_q <= '0;
         s_q.rdiv <= RDAM_RST_REF_DIV;
         s_q.rin <= RDAM_RST_REF_INPUT;
         s_q.aux <= RDAM_RST_AUX_OUT;
         s_q.nreg <= RDAM_RST_N_RATIO;
      end else begin
         s_q <= s_d;
      end
   end

   assign reg_rdata_o = s_q.rdata;
   assign pfd_ref_o = s_q.pfd;
   assign pfd_vco_o = n_out;
   assign mod_clk_o = s_q.modclk;
   assign aux_output_pin_first_o = s_q.gpo[0];
   assign aux_output_pin_second_o = s_q.gpo[1];
   assign aux_output_pin_third_o = s_q.gpo[2];

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);

   sequence s_bypass_cfg;
      (auto_mode && ratio == 14'h0001)[*2];
   endsequence
   sequence s_gpo_illegal;
      s_q.aux[3:0] inside {4'h5, 4'h8, [4'hB:4'hF]};
   endsequence

   chk_auto_bypass: assert property (
      s_bypass_cfg |=> pfd_ref_o == $past(ref_lvl))
      else $error("auto ratio one does not bypass divider");
   chk_auto_divide: assert property (
      (auto_mode && ratio >= RDAM_RATIO_MIN_DIV && s_q.path)
      |=> $past(div_run) && pfd_ref_o == $past(div_out))
      else $error("auto divider not running");
   chk_manual_stop: assert property (
      (!auto_mode && !s_q.rin[RDAM_RIN_DIV_EN]) |=> !div_out)
      else $error("manual divider runs while disabled");
   chk_manual_undiv: assert property (
      (!auto_mode && !s_q.rdiv[RDAM_RD_PATH] && !s_q.path)
      |=> pfd_ref_o == $past(ref_lvl))
      else $error("undivided path not passed");
   chk_path_boundary: assert property (
      $changed(s_q.path) |-> $past(div_wrap || !div_run))
      else $error("path changed mid divider cycle");
   chk_n_ratio_span: assert property (
      {n_half, 1'b0} >= n_lo - 17'h0_0004
      && {n_half, 1'b0} <= n_hi + 17'h0_0004)
      else $error("vco divide ratio out of range");
   chk_static_gpo: assert property (
      s_q.aux[3:0] == 4'h0 |=> {aux_output_pin_third_o,
      aux_output_pin_second_o, aux_output_pin_first_o}
      == $past(s_q.aux[6:4]))
      else $error("static data not on aux pins");
   chk_gpo_clocks: assert property (
      s_q.aux[3:0] == 4'h1 |=> aux_output_pin_third_o == $past(ref_lvl)
      && aux_output_pin_second_o == $past(div_out)
      && aux_output_pin_first_o == $past(s_q.lvl[RDAM_PIN_VCO]))
      else $error("clock routing to aux pins wrong");
   chk_gpo_undef: assert property (
      s_gpo_illegal |=> s_q.gpo == 3'h0)
      else $error("undefined select drives aux pins");
   chk_mod_clk_sq: assert property (
      (s_q.rin[RDAM_RIN_SQ2DIG] && !s_q.rin[RDAM_RIN_DSM_SIN])
      |=> mod_clk_o == $past(s_q.lvl[RDAM_PIN_SQ]))
      else $error("modulator clock not from square input");
endmodule
`default_nettype wire

// ---- pkg/rdam_pkg.sv ----
// Constants and carrier types of the reference divider and aux output mux.
`default_nettype none
package rdam_pkg;
   // ==========================================================
   // Register offsets
   localparam logic [7:0] RDAM_OFS_REF_INPUT = 8'h01;
   localparam logic [7:0] RDAM_OFS_REF_DIV = 8'h03;
   localparam logic [7:0] RDAM_OFS_AUX_OUT = 8'h1B;
   localparam logic [7:0] RDAM_OFS_N_RATIO = 8'h3D;
   localparam logic [7:0] RDAM_OFS_STATUS = 8'h3E;
   // ==========================================================
   // Field positions
   localparam int RDAM_RD_AUTO = 15;
   localparam int RDAM_RD_PATH = 14;
   localparam int RDAM_RIN_SQ_EN = 0;
   localparam int RDAM_RIN_SIN_EN = 1;
   localparam int RDAM_RIN_DIV_EN = 2;
   localparam int RDAM_RIN_SIN_SEL = 3;
   localparam int RDAM_RIN_SQ2DIG = 4;
   localparam int RDAM_RIN_DSM_SIN = 5;
   localparam int RDAM_N_FRAC = 17;
   localparam int RDAM_PIN_SQ = 0;
   localparam int RDAM_PIN_SIN = 1;
   localparam int RDAM_PIN_VCO = 2;
   // ==========================================================
   // Reset values and limits
   localparam logic [15:0] RDAM_RST_REF_DIV = 16'h8001;
   localparam logic [5:0] RDAM_RST_REF_INPUT = 6'h11;
   localparam logic [6:0] RDAM_RST_AUX_OUT = 7'h00;
   localparam logic [17:0] RDAM_RST_N_RATIO = 18'h0_0064;
   localparam logic [13:0] RDAM_RATIO_MIN_DIV = 14'h0002;
   localparam logic [16:0] RDAM_N_MIN_FRAC = 17'h0_0048;
   localparam logic [16:0] RDAM_N_MIN_INT = 17'h0_0040;
   localparam logic [16:0] RDAM_N_MAX_FRAC = 17'h1_FFF6;
   localparam logic [16:0] RDAM_N_MAX_INT = 17'h1_FFFE;
   localparam logic signed [3:0] RDAM_STEP_MAX = 4'sh4;
   // ==========================================================
   // Carriers
   typedef struct packed {
      logic en;
      logic [7:0] addr;
      logic [23:0] data;
   } rdam_reg_wr_s;
   typedef struct packed {
      logic [2:0] lock_win;
      logic [2:0] slip;
      logic frac_strobe;
      logic [2:0] dsm_acc;
      logic [2:0] aux_osc;
      logic [2:0] multi_vco;
      logic [2:0] dsm_out;
   } rdam_aux_src_s;
   typedef enum logic [3:0] {
      RDAM_GPO_STATIC = 4'h0,
      RDAM_GPO_CLOCKS = 4'h1,
      RDAM_GPO_LOCK = 4'h2,
      RDAM_GPO_SLIP = 4'h3,
      RDAM_GPO_FRAC = 4'h4,
      RDAM_GPO_ACC = 4'h6,
      RDAM_GPO_OSC = 4'h7,
      RDAM_GPO_MVCO = 4'h9,
      RDAM_GPO_DSM = 4'hA
   } rdam_gpo_sel_e;
endpackage
`default_nettype wire

// ---- design/rdam_divider.sv ----
// Programmable edge-counting divider with boundary-loaded ratio.
`default_nettype none
module rdam_divider
   import rdam_pkg::*;
#(
   parameter int W = 14
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic run_i,
   input wire logic tick_i,
   input wire logic [W-1:0] ratio_i,
   output logic out_o,
   output logic wrap_o
);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic [W-1:0] ratio;
      logic out;
      logic wrap;
   } rdam_div_s;

   rdam_div_s s_q;
   rdam_div_s s_d;
   logic last;

   // While running, a new ratio is only taken at the wrap (when stopped it
   // loads every cycle), so a write never cuts a period short and the
   // phase detector sees no runt pulse.
   always_comb begin
      s_d = s_q;
      s_d.wrap = 1'b0;
      last = (s_q.ratio <= W'(1)) || (s_q.cnt >= s_q.ratio - W'(1));
      if (!run_i) begin
         s_d.cnt = '0;
         s_d.ratio = ratio_i;
         s_d.out = 1'b0;
      end else if (tick_i) begin
         if (last) begin
            s_d.cnt = '0;
            s_d.ratio = ratio_i;
            s_d.wrap = 1'b1;
         end else begin
            s_d.cnt = s_q.cnt + W'(1);
         end
         s_d.out = s_d.cnt < (s_d.ratio - (s_d.ratio >> 1));
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign out_o = s_q.out;
   assign wrap_o = s_q.wrap;
endmodule
`default_nettype wire

// ---- sim/rdam_osc_model.sv ----
// Free-running reference and VCO prescaler oscillators for the bench.
`default_nettype none
module rdam_osc_model #(
   parameter int REF_HALF_NS = 80,
   parameter int SIN_HALF_NS = 120,
   parameter int VCO_HALF_NS = 100
) (
   output logic square_o,
   output logic sine_o,
   output logic vco_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // =========================================================
   // Oscillators
   // Half periods are multiples of 20 ns, so no pin edge meets a rising
   // clock edge and the measured periods never depend on process order.
   initial begin
      square_o = 1'b0;
      forever #(REF_HALF_NS) square_o = ~square_o;
   end
   initial begin
      sine_o = 1'b0;
      forever #(SIN_HALF_NS) sine_o = ~sine_o;
   end
   initial begin
      vco_o = 1'b0;
      forever #(VCO_HALF_NS) vco_o = ~vco_o;
   end
endmodule
`default_nettype wire

// ---- sim/ref_divider_and_aux_output_mux_test.sv ----
// Register-level tests of the reference divider and aux output mux.
`default_nettype none
module ref_divider_and_aux_output_mux_test
   import rdam_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i;
   logic rst_n_i;
   logic sq, sn, vco;
   rdam_reg_wr_s reg_wr_i;
   logic reg_rd_i;
   logic [7:0] reg_rd_addr_i;
   logic signed [3:0] dsm_step_i;
   rdam_aux_src_s aux_src_i;
   logic [23:0] reg_rdata_o;
   logic pfd_ref_o, pfd_vco_o, mod_clk_o;
   logic first, second, third;
   logic [23:0] q;
   logic [23:0] pins;
   logic [3:0] sels[6] = '{4'h2, 4'h3, 4'h6, 4'h7, 4'h9, 4'hA};
   logic [3:0] bad[7] = '{4'h5, 4'h8, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF};
   int fail_count;
   int num_checks;
   // =========================================================
   // Design and partner
   rdam_osc_model u_rdam_osc_model (.square_o(sq), .sine_o(sn), .vco_o(vco));
   rdam_top u_rdam_top (
      .clk_i(clk_i), .rst_n_i(rst_n_i),
      .square_reference_pin_i(sq), .sine_reference_pin_i(sn),
      .vco_prescaler_pin_i(vco), .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i), .reg_rd_addr_i(reg_rd_addr_i),
      .dsm_step_i(dsm_step_i), .aux_src_i(aux_src_i),
      .reg_rdata_o(reg_rdata_o), .pfd_ref_o(pfd_ref_o),
      .pfd_vco_o(pfd_vco_o), .mod_clk_o(mod_clk_o),
      .aux_output_pin_first_o(first), .aux_output_pin_second_o(second),
      .aux_output_pin_third_o(third));
   always #10 clk_i = ~clk_i;
   assign pins = {21'h00_0000, third, second, first};
   // =========================================================
   // Tasks
   task automatic check(input string what, input logic [23:0] seen,
                        input logic [23:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [23:0] d);
      @(posedge clk_i) reg_wr_i <= '{en: 1'b1, addr: a, data: d};
      @(posedge clk_i) reg_wr_i.en <= 1'b0;
      repeat (64) @(posedge clk_i);
   endtask
   task automatic rd(input logic [7:0] a, output logic [23:0] d);
      @(posedge clk_i) begin
         reg_rd_i <= 1'b1;
         reg_rd_addr_i <= a;
      end
      @(posedge clk_i) reg_rd_i <= 1'b0;
      // Read data is launched at the edge that takes the read, so it is
      // taken at the falling edge after it, where it has settled.
      @(negedge clk_i) d = reg_rdata_o;
   endtask
   task automatic status(input logic [1:0] exp);
      logic [23:0] d;
      rd(8'h3E, d);
      check("running and divided flags", {22'h00_0000, d[4:3]}, {22'h0, exp});
   endtask
   function automatic logic pick(input int code);
      case (code)
         0: return pfd_ref_o;
         1: return mod_clk_o;
         2: return third;
         3: return second;
         default: return first;
      endcase
   endfunction
   task automatic period(input int code, input logic [23:0] exp);
      int n;
      int st;
      logic p;
      logic c;
      n = 0;
      st = 0;
      p = pick(code);
      repeat (4000) begin
         @(negedge clk_i);
         c = pick(code);
         if (c === 1'b1 && p === 1'b0) st++;
         if (st == 1) n++;
         p = c;
         if (st == 2) break;
      end
      check($sformatf("period of output %0d", code), 24'(n), exp);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // =========================================================
   // Watchdog
   initial begin
      #400_000;
      fail_count++;
      tally_and_finish();
   end
   // =========================================================
   // Tests
   initial begin
      clk_i = 1'b0;
      rst_n_i = 1'b0;
      reg_wr_i = '0;
      reg_rd_i = 1'b0;
      reg_rd_addr_i = 8'h00;
      dsm_step_i = 4'sh0;
      aux_src_i = '{lock_win: 3'h1, slip: 3'h2, frac_strobe: 1'b1,
                    dsm_acc: 3'h3, aux_osc: 3'h4, multi_vco: 3'h5,
                    dsm_out: 3'h6};
      fail_count = 0;
      num_checks = 0;
      repeat (16) @(posedge clk_i);
      rst_n_i <= 1'b1;
      rd(8'h03, q);
      check("divider control reset", q, 24'h00_8001);
      rd(8'h01, q);
      check("input control reset", q, 24'h00_0011);
      rd(8'h1B, q);
      check("aux control reset", q, 24'h00_0000);
      rd(8'h7F, q);
      check("unmapped read", q, 24'h00_0000);
      $display("test reset values done");
      period(0, 24'h00_0008);
      status(2'b00);
      wr(8'h03, 24'h00_8003);
      period(0, 24'h00_0018);
      status(2'b11);
      wr(8'h01, 24'h00_0015);
      wr(8'h03, 24'h00_4003);
      period(0, 24'h00_0018);
      wr(8'h03, 24'h00_0003);
      period(0, 24'h00_0008);
      status(2'b01);
      wr(8'h01, 24'h00_0011);
      wr(8'h03, 24'h00_4003);
      status(2'b10);
      $display("test divider control done");
      wr(8'h03, 24'h00_8001);
      wr(8'h01, 24'h00_001B);
      period(0, 24'h00_000C);
      period(1, 24'h00_0008);
      wr(8'h01, 24'h00_0033);
      period(0, 24'h00_0008);
      period(1, 24'h00_000C);
      wr(8'h01, 24'h00_0011);
      period(0, 24'h00_0008);
      period(1, 24'h00_0008);
      $display("test modulator clock done");
      wr(8'h03, 24'h00_8003);
      wr(8'h1B, 24'h00_0001);
      period(2, 24'h00_0008);
      period(3, 24'h00_0018);
      period(4, 24'h00_000A);
      wr(8'h1B, 24'h00_0004);
      period(2, 24'h00_000C);
      period(3, 24'h00_0018);
      check("strobe pin", {23'h00_0000, first}, 24'h00_0001);
      for (int v = 0; v < 8; v++) begin
         wr(8'h1B, {17'h0_0000, 3'(v), 4'h0});
         check("static pins", pins, 24'(v));
      end
      rd(8'h1B, q);
      check("aux control readback", q, 24'h00_0070);
      for (int i = 0; i < 6; i++) begin
         wr(8'h1B, {20'h0_0000, sels[i]});
         check("sourced pins", pins, 24'(i + 1));
      end
      for (int i = 0; i < 7; i++) begin
         wr(8'h1B, {17'h0_0000, 3'h7, bad[i]});
         check("undefined select pins", pins, 24'h00_0000);
      end
      rd(8'h03, q);
      check("divider control kept", q, 24'h00_8003);
      period(0, 24'h00_0018);
      $display("test aux outputs done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
